// file: include/pnpc_params.svh
// Offsets, field positions, reset and fixed values of the config bank
`ifndef PNPC_PARAMS_SVH
`define PNPC_PARAMS_SVH

// ----------------------------------------------------------------
// Configuration locations
// ----------------------------------------------------------------
`define PNPC_LOC_ACTIVATE    8'h30
`define PNPC_LOC_SHM_HIGH    8'h40
`define PNPC_LOC_SHM_MID     8'h41
`define PNPC_LOC_SHM_CTRL    8'h42
`define PNPC_LOC_RANGE_HIGH  8'h43
`define PNPC_LOC_RANGE_LOW   8'h44
`define PNPC_LOC_SER_HIGH    8'h60
`define PNPC_LOC_SER_LOW     8'h61
`define PNPC_LOC_FIR_HIGH    8'h62

// ----------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------
`define PNPC_RANGE_HIGH_VAL  8'hff
`define PNPC_RANGE_LOW_VAL   8'he0
`define PNPC_SHM_CTRL_VAL    8'h00
`define PNPC_BASE_RST        8'h00
`define PNPC_ACT_RST         1'h0
`define PNPC_UNMAPPED_VAL    8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PNPC_ACT_BIT         0
`define PNPC_SHM_MID_LSB     5
`define PNPC_SER_LOW_LSB     3

`endif

// file: include/pnpc_pkg.sv
// Types shared by the configuration bank and its cycle decoder
package pnpc_pkg;

  // One ISA bus cycle as seen by the claim logic
  typedef struct packed {
    logic        mem;
    logic        io;
    logic [23:0] addr;
  } pnpc_cycle_t;

  // Programmed bases handed to the rest of the controller
  typedef struct packed {
    logic        active;
    logic [10:0] shm_base;
    logic [12:0] ser_base;
    logic [7:0]  fir_base_high;
  } pnpc_bases_t;

endpackage

// file: logic/pnpc_decode.sv
// Claim decoder for memory window and serial-port I/O cycles
`timescale 1ns/1ns

module pnpc_decode
  import pnpc_pkg::*;
(
  input  wire pnpc_bases_t bases,
  input  wire logic        shm_mode,
  input  wire pnpc_cycle_t cyc,
  output wire logic        mem_hit,
  output wire logic        ser_hit
);

  wire logic mem_match;
  wire logic ser_match;

  // Window is 8 Kbyte and size aligned, so bits 12:0 never compare
  assign mem_match = (cyc.addr[23:13] == bases.shm_base);
  assign ser_match = (cyc.addr[15:3] == bases.ser_base);

  assign mem_hit = bases.active & shm_mode & cyc.mem & mem_match;
  assign ser_hit = bases.active & cyc.io & ser_match;

endmodule

// file: logic/pnpc_regs.sv
// Plug-and-play resource configuration bank with cycle claim outputs
`timescale 1ns/1ns
`include "pnpc_params.svh"

// What this block does
// - Location 40h sets window address bits 23:16
// - Location 41h sets window address bits 15:8
// - Window bits 12:8 ignore writes, read zero
// - Control bits 7:2 read-only zero
// - Width bit reads zero, accesses 8-bit
// - Range/limit bit reads zero, means size
// - Location 43h reads constant FFh
// - Location 44h reads E0h, 8 Kbyte window
// - Location 60h sets serial base upper byte
// - Location 61h serial low, bits 2:0 zero
// - Location 62h sets infrared base upper byte
// - Inactive device claims no bus cycles
module pnpc_regs
  import pnpc_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [7:0]  CFG_WDATA,
  input  wire logic        SHM_MODE,
  input  wire pnpc_cycle_t BUS_CYC,
  output logic      [7:0]  CFG_RDATA,
  output logic             MEM_CLAIM,
  output logic             SER_CLAIM,
  output pnpc_bases_t      BASES
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic       act_r;
  logic [7:0] shm_high_r;
  logic [2:0] shm_mid_r;
  logic [7:0] ser_high_r;
  logic [4:0] ser_low_r;
  logic [7:0] fir_high_r;
  logic [7:0] rdata_r;
  logic       mem_claim_r;
  logic       ser_claim_r;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire logic wr_act;
  wire logic wr_shm_high;
  wire logic wr_shm_mid;
  wire logic wr_ser_high;
  wire logic wr_ser_low;
  wire logic wr_fir_high;

  assign wr_act      = CFG_WR & (CFG_ADDR == `PNPC_LOC_ACTIVATE);
  assign wr_shm_high = CFG_WR & (CFG_ADDR == `PNPC_LOC_SHM_HIGH);
  assign wr_shm_mid  = CFG_WR & (CFG_ADDR == `PNPC_LOC_SHM_MID);
  assign wr_ser_high = CFG_WR & (CFG_ADDR == `PNPC_LOC_SER_HIGH);
  assign wr_ser_low  = CFG_WR & (CFG_ADDR == `PNPC_LOC_SER_LOW);
  assign wr_fir_high = CFG_WR & (CFG_ADDR == `PNPC_LOC_FIR_HIGH);

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  // Control, range and the zero fields keep no storage, so a write
  // to them simply has nowhere to land
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      act_r      <= `PNPC_ACT_RST;
      shm_high_r <= `PNPC_BASE_RST;
      shm_mid_r  <= 3'h0;
      ser_high_r <= `PNPC_BASE_RST;
      ser_low_r  <= 5'h00;
      fir_high_r <= `PNPC_BASE_RST;
    end
    else
    begin
      if (wr_act)
        act_r <= CFG_WDATA[`PNPC_ACT_BIT];
      if (wr_shm_high)
        shm_high_r <= CFG_WDATA;
      if (wr_shm_mid)
        shm_mid_r <= CFG_WDATA[7:`PNPC_SHM_MID_LSB];
      if (wr_ser_high)
        ser_high_r <= CFG_WDATA;
      if (wr_ser_low)
        ser_low_r <= CFG_WDATA[7:`PNPC_SER_LOW_LSB];
      if (wr_fir_high)
        fir_high_r <= CFG_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  wire logic [7:0] shm_mid_val;
  wire logic [7:0] ser_low_val;
  logic      [7:0] rd_sel;

  assign shm_mid_val = {shm_mid_r, 5'h00};
  assign ser_low_val = {ser_low_r, 3'h0};

  always_comb
  begin
    unique case (CFG_ADDR)
      `PNPC_LOC_ACTIVATE:   rd_sel = {7'h00, act_r};
      `PNPC_LOC_SHM_HIGH:   rd_sel = shm_high_r;
      `PNPC_LOC_SHM_MID:    rd_sel = shm_mid_val;
      `PNPC_LOC_SHM_CTRL:   rd_sel = `PNPC_SHM_CTRL_VAL;
      `PNPC_LOC_RANGE_HIGH: rd_sel = `PNPC_RANGE_HIGH_VAL;
      `PNPC_LOC_RANGE_LOW:  rd_sel = `PNPC_RANGE_LOW_VAL;
      `PNPC_LOC_SER_HIGH:   rd_sel = ser_high_r;
      `PNPC_LOC_SER_LOW:    rd_sel = ser_low_val;
      `PNPC_LOC_FIR_HIGH:   rd_sel = fir_high_r;
      default:              rd_sel = `PNPC_UNMAPPED_VAL;
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      rdata_r <= `PNPC_UNMAPPED_VAL;
    else if (CFG_RD)
      rdata_r <= rd_sel;
  end

  // ----------------------------------------------------------------
  // Bus cycle claims
  // ----------------------------------------------------------------
  pnpc_bases_t bases_w;
  wire logic   mem_hit;
  wire logic   ser_hit;

  // Bits 23:20 are stored as written; keeping them zero is host duty
  assign bases_w.active        = act_r;
  assign bases_w.shm_base      = {shm_high_r, shm_mid_r};
  assign bases_w.ser_base      = {ser_high_r, ser_low_r};
  assign bases_w.fir_base_high = fir_high_r;

  pnpc_decode u_decode (
    .bases    (bases_w),
    .shm_mode (SHM_MODE),
    .cyc      (BUS_CYC),
    .mem_hit  (mem_hit),
    .ser_hit  (ser_hit)
  );

  // One cycle of latency buys flop-driven claim outputs
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mem_claim_r <= 1'b0;
      ser_claim_r <= 1'b0;
    end
    else
    begin
      mem_claim_r <= mem_hit;
      ser_claim_r <= ser_hit;
    end
  end

  assign CFG_RDATA = rdata_r;
  assign MEM_CLAIM = mem_claim_r;
  assign SER_CLAIM = ser_claim_r;
  assign BASES     = bases_w;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  sequence seq_wr_mid;
    CFG_WR && CFG_ADDR == `PNPC_LOC_SHM_MID;
  endsequence

  sequence seq_rd_mid;
    CFG_RD && !CFG_WR && CFG_ADDR == `PNPC_LOC_SHM_MID;
  endsequence

  AST_HIGH_WRITE: assert property (
    CFG_WR && CFG_ADDR == `PNPC_LOC_SHM_HIGH |=>
      shm_high_r == $past(CFG_WDATA))
    else $error("window high byte not stored");

  AST_MID_READBACK: assert property (
    seq_wr_mid ##1 seq_rd_mid |=>
      CFG_RDATA == {$past(CFG_WDATA, 2) & 8'he0})
    else $error("window mid byte readback wrong");

  AST_MID_LOW_ZERO: assert property (
    CFG_RD && CFG_ADDR == `PNPC_LOC_SHM_MID |=> CFG_RDATA[4:0] == 5'h00)
    else $error("window mid bits 12:8 not zero");

  AST_CTRL_ZERO: assert property (
    CFG_RD && CFG_ADDR == `PNPC_LOC_SHM_CTRL |=>
      CFG_RDATA == `PNPC_SHM_CTRL_VAL)
    else $error("control register not zero");

  AST_CTRL_BITS: assert property (
    CFG_RD && CFG_ADDR == `PNPC_LOC_SHM_CTRL |=>
      !CFG_RDATA[1] && !CFG_RDATA[0])
    else $error("width or range bit set");

  AST_CTRL_RANGE_USE: assert property (
    CFG_RD && CFG_ADDR == `PNPC_LOC_SHM_CTRL |=> !CFG_RDATA[0])
    else $error("range usage bit set");

  AST_RANGE_HIGH: assert property (
    CFG_RD && CFG_ADDR == `PNPC_LOC_RANGE_HIGH |=>
      CFG_RDATA == `PNPC_RANGE_HIGH_VAL)
    else $error("range high byte not ff");

  AST_RANGE_LOW: assert property (
    CFG_RD && CFG_ADDR == `PNPC_LOC_RANGE_LOW |=>
      CFG_RDATA == `PNPC_RANGE_LOW_VAL)
    else $error("range low byte not e0");

  AST_SER_HIGH: assert property (
    CFG_WR && CFG_ADDR == `PNPC_LOC_SER_HIGH |=> BASES.ser_base[12:5] ==
      $past(CFG_WDATA))
    else $error("serial high byte not stored");

  AST_SER_LOW: assert property (
    CFG_WR && CFG_ADDR == `PNPC_LOC_SER_LOW |=> BASES.ser_base[4:0] ==
      $past(CFG_WDATA[7:3]))
    else $error("serial low byte not stored");

  AST_FIR_HIGH: assert property (
    CFG_WR && CFG_ADDR == `PNPC_LOC_FIR_HIGH |=> BASES.fir_base_high ==
      $past(CFG_WDATA))
    else $error("infrared high byte not stored");

  AST_INACTIVE: assert property (
    !act_r |=> !MEM_CLAIM && !SER_CLAIM)
    else $error("claim while inactive");

  AST_MEM_CLAIM: assert property (
    act_r && SHM_MODE && BUS_CYC.mem &&
      BUS_CYC.addr[23:13] == {shm_high_r, shm_mid_r}
      |=> MEM_CLAIM)
    else $error("window cycle not claimed");

  AST_SER_CLAIM: assert property (
    $rose(SER_CLAIM) |-> $past(act_r) && $past(BUS_CYC.io) &&
      $past(BUS_CYC.addr[15:3]) == $past(BASES.ser_base))
    else $error("serial claim without match");

endmodule

// file: verification/pnpc_host_model.sv
// Host model issuing configuration cycles on the register port
`timescale 1ns/1ns

module pnpc_host_model (
  input  wire logic       clk,
  output logic            cfg_wr,
  output logic            cfg_rd,
  output logic [7:0]      cfg_addr,
  output logic [7:0]      cfg_wdata,
  input  wire logic [7:0] cfg_rdata
);
  // Cleared only by a scenario that breaks the host duties on purpose
  logic strict = 1'b1;

  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
  end

  function automatic logic [7:0] legal(input logic [7:0] a,
                                       input logic [7:0] d);
    legal = d;
    if (strict && a == 8'h40)
      legal = {4'h0, d[3:0]};
    if (strict && a == 8'h41)
      legal = {d[7:5], 5'h00};
  endfunction

  // Write, then read back on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    logic [7:0] v;
    v = legal(a, d);
    @(posedge clk);
    #1 cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = v;
    @(posedge clk);
    #1 cfg_wr = 1'b0;
    cfg_rd = 1'b1;
    cfg_wdata = ~v;
    @(posedge clk);
    #1 cfg_rd = 1'b0;
    cfg_addr = ~a;
    q = cfg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = legal(a, d);
    @(posedge clk);
    #1 cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = v;
    @(posedge clk);
    #1 cfg_wr = 1'b0;
    // Released lines do not keep the last value
    cfg_addr = ~a;
    cfg_wdata = ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk);
    #1 cfg_rd = 1'b0;
    cfg_addr = ~a;
    d = cfg_rdata;
  endtask
endmodule

// file: verification/pnpc_regs_tb.sv
// Self-checking testbench for the configuration bank
`timescale 1ns/1ns
`include "pnpc_params.svh"

module pnpc_regs_tb
  import pnpc_pkg::*;
;
  logic        ref_clk;
  logic        rstn;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_wdata;
  logic [7:0]  cfg_rdata;
  logic        shm_mode;
  pnpc_cycle_t bus_cyc;
  logic        mem_claim;
  logic        ser_claim;
  pnpc_bases_t bases;
  logic [7:0]  d;
  int          fails = 0;
  int          cmp_count = 0;
  logic [7:0]  loc [9] = '{8'h30, 8'h40, 8'h41, 8'h42, 8'h43,
                           8'h44, 8'h60, 8'h61, 8'h62};
  logic [7:0]  rst_val [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
                               8'he0, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wr_val [9] = '{8'h00, 8'h0a, 8'he0, 8'h00, 8'hff,
                              8'he0, 8'h12, 8'hf8, 8'h34};

  pnpc_regs i_dut (
    .REF_CLK   (ref_clk),
    .RSTN      (rstn),
    .CFG_WR    (cfg_wr),
    .CFG_RD    (cfg_rd),
    .CFG_ADDR  (cfg_addr),
    .CFG_WDATA (cfg_wdata),
    .SHM_MODE  (shm_mode),
    .BUS_CYC   (bus_cyc),
    .CFG_RDATA (cfg_rdata),
    .MEM_CLAIM (mem_claim),
    .SER_CLAIM (ser_claim),
    .BASES     (bases)
  );

  pnpc_host_model i_host (
    .clk       (ref_clk),
    .cfg_wr    (cfg_wr),
    .cfg_rd    (cfg_rd),
    .cfg_addr  (cfg_addr),
    .cfg_wdata (cfg_wdata),
    .cfg_rdata (cfg_rdata)
  );

  always #10 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [32:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic cyc(input logic m, io, input logic [23:0] a,
                     input logic sm, em, es);
    @(posedge ref_clk);
    #1 bus_cyc = '{mem: m, io: io, addr: a};
    shm_mode = sm;
    @(posedge ref_clk);
    #1 chk("mem_claim", {32'h0, em}, {32'h0, mem_claim});
    chk("ser_claim", {32'h0, es}, {32'h0, ser_claim});
    bus_cyc = '0;
  endtask

  task automatic results;
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Run is far shorter than this; a hang ends here
  initial
  begin
    #200000;
    fails++;
    results;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    shm_mode = 1'b1;
    bus_cyc = '0;
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1'b1;
    chk("bases", 33'h0, bases);
    for (int i = 0; i < 9; i++)
    begin
      i_host.rd(loc[i], d);
      chk("cfg_rdata", {25'h0, rst_val[i]}, {25'h0, d});
    end
    i_host.rd(8'h50, d);
    chk("unmapped", {25'h0, `PNPC_UNMAPPED_VAL}, {25'h0, d});
    i_host.wr(8'h40, 8'h0a);
    i_host.strict = 1'b0;
    i_host.wr(8'h41, 8'hff);
    i_host.strict = 1'b1;
    i_host.wr(8'h60, 8'h12);
    i_host.wr(8'h61, 8'hff);
    i_host.wr(8'h62, 8'h34);
    i_host.wr(8'h42, 8'hff);
    i_host.wr(8'h43, 8'h5a);
    i_host.wr(8'h44, 8'h5a);
    for (int i = 0; i < 9; i++)
    begin
      i_host.rd(loc[i], d);
      chk("cfg_rdata", {25'h0, wr_val[i]}, {25'h0, d});
    end
    chk("bases", {1'b0, 11'h057, 13'h025f, 8'h34}, bases);
    i_host.wr_rd(8'h41, 8'h7f, d);
    chk("shm_mid", 33'h60, {25'h0, d});
    cyc(1'b1, 1'b0, 24'h0a6000, 1'b1, 1'b0, 1'b0);
    cyc(1'b0, 1'b1, 24'h0012f8, 1'b1, 1'b0, 1'b0);
    i_host.wr(8'h30, 8'h01);
    i_host.rd(8'h30, d);
    chk("activate", 33'h1, {25'h0, d});
    cyc(1'b1, 1'b0, 24'h0a7fff, 1'b1, 1'b1, 1'b0);
    cyc(1'b1, 1'b0, 24'h0a8000, 1'b1, 1'b0, 1'b0);
    cyc(1'b1, 1'b0, 24'h0a6000, 1'b0, 1'b0, 1'b0);
    cyc(1'b0, 1'b1, 24'hff12ff, 1'b1, 1'b0, 1'b1);
    cyc(1'b0, 1'b1, 24'h001300, 1'b1, 1'b0, 1'b0);
    cyc(1'b1, 1'b0, 24'h0012f8, 1'b1, 1'b0, 1'b0);
    // Reset in mid-run clears bases and read data
    rstn = 1'b0;
    @(posedge ref_clk);
    #1 chk("bases", 33'h0, bases);
    chk("cfg_rdata", 33'h0, {25'h0, cfg_rdata});
    chk("mem_claim", 33'h0, {32'h0, mem_claim});
    chk("ser_claim", 33'h0, {32'h0, ser_claim});
    rstn = 1'b1;
    i_host.rd(8'h40, d);
    chk("cfg_rdata", 33'h0, {25'h0, d});
    results;
  end
endmodule
